// [tb/tb.sv]
// self-checking bench for the translation fault unit
`timescale 1ns/100ps
`default_nettype none
module tb;
  import xlate_pkg::*;
  localparam logic [19:0] RPN = 20'hA5C31;
  localparam logic [31:0] B1 = 32'h4000_0000, B3 = 32'h1000_0000, B4 = 32'h0800_0000;
  localparam logic [31:0] B5 = 32'h0400_0000, B11 = 32'h0010_0000;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, req_valid = '0;
  logic req_fetch = '0, bat_hit = '0, bat_prot_ok = '0, bat_guard = '0, bat_ci = '0;
  logic bat_wt = '0, walk_wt = '0, walk_ci = '0;
  logic pready, pslverr, req_ready, walk_req, walk_done, walk_found, walk_guard;
  logic resp_valid, resp_real;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, req_ea = '0, req_iaddr = '0, bat_pa = 32'h7B40_0000;
  logic [31:0] prdata, resp_pa, resp_sms, resp_dfc, resp_fault_iaddr, ea, e1, e2, ia;
  logic [2:0] cfg = '0;
  logic [1:0] walk_pp;
  logic [19:0] walk_rpn;
  logic [51:0] walk_vaddr;
  logic [23:0] vsid;
  op_t req_op = OP_LOAD;
  fault_t resp_fault;
  int mismatches = 0, n_compared = 0, cyc = 0;
  logic [98:0] q[$];
  xlate_fault_unit xlate_fault_unit_i (.*);
  walk_model #(.RPN(RPN)) walk_model_i (.*);
  always #50 pclk = ~pclk;
  task automatic cmp(input logic [98:0] g, e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // watchdog, result monitor and search address monitor
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end else begin
      if (resp_valid === 1'b1) cmp({resp_real, resp_fault, resp_sms, resp_dfc,
        resp_fault === FAULT_NONE ? resp_pa : resp_fault_iaddr}, q.pop_front());
      if (walk_done === 1'b1) cmp(99'(walk_vaddr), 99'({vsid, req_ea[27:0]}));
    end
  end
  task automatic apb(input logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) cmp(99'({pslverr, prdata}), 99'(e));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // b packs walk answer and block lookup; v is pa when clean, else cause bits
  task automatic rq(input logic f, op_t op, logic [31:0] a, logic [6:0] b, fault_t ef,
                    logic [31:0] v);
    @(posedge pclk);
    ia = $urandom;
    req_valid <= 1'b1;
    req_fetch <= f;
    req_op <= op;
    req_ea <= a;
    req_iaddr <= ia;
    {cfg, bat_hit, bat_prot_ok, bat_guard, bat_ci} <= b;
    q.push_back({ef == FAULT_NONE && v == a, ef, ef == FAULT_INSTR ? v : '0,
      ef == FAULT_DATA ? v : '0, ef == FAULT_NONE ? v : ia});
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // block and search answers must stand until the result, retry lookup included
    do @(posedge pclk); while (resp_valid !== 1'b1);
    $display("test at ea %h done", a);
  endtask : rq
  // main sequence
  initial begin
    void'($urandom(32'hA04C_AF7A));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    ea = $urandom & 32'h0FFF_FFFC;
    e1 = ea | 32'h1000_0000;
    e2 = ea | 32'h2000_0000;
    vsid = 24'($urandom);
    apb(1'b0, CTRL_OFF, '0, '0);
    apb(1'b0, 12'hFFC, '0, {1'b1, 32'h0});
    apb(1'b1, SEG_OFF + 12'h004, 32'h8000_0000, '0);
    apb(1'b1, SEG_OFF + 12'h008, 32'h1000_0000, '0);
    apb(1'b1, SEG_OFF, {8'h00, vsid}, '0);
    rq(1'b1, OP_LOAD, ea, 7'h04, FAULT_NONE, ea);
    rq(1'b0, OP_STORE, e1, 7'h04, FAULT_NONE, e1);
    apb(1'b1, CTRL_OFF, 32'h0000_0007, '0);
    rq(1'b0, OP_LMW, ea, 7'h04, FAULT_ALIGN, '0);
    apb(1'b1, CTRL_OFF, 32'h0000_0003, '0);
    rq(1'b0, OP_LOAD, ea, 7'h0C, FAULT_NONE, bat_pa);
    rq(1'b1, OP_LOAD, ea, 7'h0E, FAULT_INSTR, B3);
    rq(1'b0, OP_STORE, ea, 7'h08, FAULT_DATA, B4);
    rq(1'b0, OP_CACHE_ZERO, ea, 7'h0D, FAULT_ALIGN, '0);
    bat_wt <= 1'b1;
    rq(1'b0, OP_CACHE_ZERO, ea, 7'h0C, FAULT_ALIGN, '0);
    bat_wt <= 1'b0;
    rq(1'b1, OP_LOAD, e1, 7'h04, FAULT_INSTR, B3);
    rq(1'b0, OP_FP_LOAD, e1, 7'h04, FAULT_DATA, B5);
    rq(1'b0, OP_LOAD_RESERVE, e1, 7'h04, FAULT_DATA, B5);
    rq(1'b1, OP_LOAD, e2, 7'h04, FAULT_INSTR, B3);
    rq(1'b0, OP_EXT_IN, ea, 7'h04, FAULT_DATA, B11);
    rq(1'b0, OP_FP_LOAD, ea | 32'h2, 7'h04, FAULT_ALIGN, '0);
    rq(1'b0, OP_LOAD, ea, 7'h54, FAULT_NONE, {RPN, ea[11:0]});
    rq(1'b0, OP_LOAD, ea, 7'h04, FAULT_NONE, {RPN, ea[11:0]});
    apb(1'b1, CTRL_OFF, 32'h0000_0013, '0);
    rq(1'b0, OP_LOAD, ea, 7'h04, FAULT_DATA, B1);
    rq(1'b0, OP_LOAD, ea ^ 32'h1000, 7'h04, FAULT_DATA, B1);
    rq(1'b0, OP_STORE, ea ^ 32'h2000, 7'h44, FAULT_DATA, B4);
    walk_wt <= 1'b1;
    rq(1'b0, OP_CACHE_ZERO, ea ^ 32'h3000, 7'h54, FAULT_ALIGN, '0);
    walk_wt <= 1'b0;
    walk_ci <= 1'b1;
    rq(1'b0, OP_CACHE_ZERO, ea ^ 32'h4000, 7'h54, FAULT_ALIGN, '0);
    walk_ci <= 1'b0;
    rq(1'b1, OP_LOAD, ea, 7'h74, FAULT_INSTR, B3);
    apb(1'b0, FPC_OFF, '0, {1'b0, ia});
    apb(1'b0, STAT_OFF, '0, 33'h0_0000_0009);
    repeat (4) @(posedge pclk);
    stop_test();
  end
endmodule : tb
`default_nettype wire

// [tb/walk_model.sv]
// page table search responder
`timescale 1ns/100ps
`default_nettype none
module walk_model #(parameter logic [19:0] RPN = 20'hA5C31) (
  input  wire logic       pclk,       // clock
  input  wire logic       presetn,    // reset, low
  input  wire logic       walk_req,   // search request
  input  wire logic [2:0] cfg,        // found, guard, pp msb
  output logic            walk_done,  // answer pulse
  output logic            walk_found, // entry found
  output logic [19:0]     walk_rpn,   // frame number
  output logic [1:0]      walk_pp,    // protection
  output logic            walk_guard  // guarded
);
  logic [1:0] cnt_q; // search latency
  // fields are junk outside done, so stale values cannot pass
  assign walk_found = cfg[2] ^ ~walk_done;
  assign walk_guard = cfg[1] ^ ~walk_done;
  assign walk_pp    = {cfg[0], 1'b0} ^ {2{~walk_done}};
  assign walk_rpn   = RPN ^ {20{~walk_done}};
  // answer a few cycles after the request rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 2'h0;
      walk_done <= 1'b0;
    end else begin
      walk_done <= walk_req && !walk_done && cnt_q == 2'h2;
      cnt_q     <= walk_req && !walk_done ? cnt_q + 2'h1 : 2'h0;
    end
  end
endmodule : walk_model
`default_nettype wire

// [verilog/xlate_fault_unit.sv]
// address translation selection and fault classification for fetch and data
`timescale 1ns/100ps
`default_nettype none
module xlate_fault_unit
  import xlate_pkg::*;
#(
  parameter int TLB_IW = 4                          // log2 of entries per buffer
) (
  input  wire logic               pclk,             // core clock
  input  wire logic               presetn,          // async reset, low
  input  wire logic               psel,             // apb select
  input  wire logic               penable,          // apb access phase
  input  wire logic               pwrite,           // apb write
  input  wire logic [11:0]        paddr,            // apb byte address
  input  wire logic [31:0]        pwdata,           // apb write data
  output logic      [31:0]        prdata,           // apb read data
  output logic                    pready,           // apb ready
  output logic                    pslverr,          // apb error, unmapped
  input  wire logic               req_valid,        // access request
  input  wire logic               req_fetch,        // 1 fetch, 0 data
  input  wire op_t                req_op,           // data operation class
  input  wire logic [EA_W-1:0]    req_ea,           // effective_address
  input  wire logic [EA_W-1:0]    req_iaddr,        // address of the instruction
  output logic                    req_ready,        // unit can take a request
  input  wire logic               bat_hit,          // block_translation_entry hit
  input  wire logic [EA_W-1:0]    bat_pa,           // block physical address
  input  wire logic               bat_prot_ok,      // block protection allows
  input  wire logic               bat_guard,        // block_guard_bit
  input  wire logic               bat_wt,           // block write-through
  input  wire logic               bat_ci,           // block caching-inhibited
  output logic                    walk_req,         // table search request
  output logic      [VA_W-1:0]    walk_vaddr,       // virtual address searched
  input  wire logic               walk_done,        // search finished, pulse
  input  wire logic               walk_found,       // page_table_entry found
  input  wire logic [RPN_W-1:0]   walk_rpn,         // page frame number
  input  wire logic [1:0]         walk_pp,          // page protection code
  input  wire logic               walk_guard,       // page_guard_bit
  input  wire logic               walk_wt,          // page write-through
  input  wire logic               walk_ci,          // page caching-inhibited
  output logic                    resp_valid,       // result pulse
  output logic                    resp_real,        // real addressing used
  output logic      [EA_W-1:0]    resp_pa,          // physical address
  output fault_t                  resp_fault,       // encoded fault type
  output logic      [31:0]        resp_sms,         // saved_machine_state bits
  output logic      [31:0]        resp_dfc,         // data_fault_cause bits
  output logic      [EA_W-1:0]    resp_fault_iaddr  // failing instruction
);

  localparam int NE    = 1 << TLB_IW;
  localparam int TAG_W = VA_W - PG_SH - TLB_IW;

  // ==========================================================================
  // state
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0]       seg_q [16];
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  state_t            state_q;
  logic              req_ready_q;
  logic              fetch_q;
  op_t               op_q;
  logic [EA_W-1:0]   ea_q;
  logic [EA_W-1:0]   iaddr_q;
  logic              walk_req_q;
  logic [VA_W-1:0]   walk_vaddr_q;
  logic              resp_valid_q;
  logic              resp_real_q;
  logic [EA_W-1:0]   resp_pa_q;
  fault_t            resp_fault_q;
  fault_t            last_fault_q;
  logic [31:0]       resp_sms_q;
  logic [31:0]       resp_dfc_q;
  logic [EA_W-1:0]   resp_iaddr_q;
  logic              tlb_v_q    [2][NE];
  logic [TAG_W-1:0]  tlb_tag_q  [2][NE];
  logic [RPN_W-1:0]  tlb_rpn_q  [2][NE];
  logic [4:0]        tlb_attr_q [2][NE];

  // ==========================================================================
  // apb decode; the answer comes one cycle into the access phase
  wire        apb_take  = psel && penable && pready_q;
  wire        apb_wr    = apb_take && pwrite;
  wire        hit_ctrl  = paddr == CTRL_OFF;
  wire        hit_stat  = paddr == STAT_OFF;
  wire        hit_fpc   = paddr == FPC_OFF;
  wire        hit_seg   = paddr[11:6] == SEG_OFF[11:6] && paddr[1:0] == 2'h0;
  wire [3:0]  seg_wi    = paddr[5:2];
  wire        map_ok    = hit_ctrl || hit_stat || hit_fpc || hit_seg;
  wire        tlb_flush = apb_wr && hit_ctrl && pwdata[CTRL_FLUSH];
  wire [31:0] stat_word = {26'h0, state_q, 1'b0, last_fault_q};
  wire [31:0] rd_word   = hit_ctrl ? {28'h0, ctrl_q} :
                          hit_stat ? stat_word :
                          hit_fpc  ? resp_iaddr_q :
                          hit_seg  ? seg_q[seg_wi] : 32'h0;

  // bus answer flops; the read word is caught on the edge that raises ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel && penable && !pready_q;
      prdata_q  <= rd_word;
      pslverr_q <= psel && penable && !pready_q && !map_ok;
    end
  end

  // control and segment registers; writes land on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      for (int i = 0; i < 16; i++) seg_q[i] <= 32'h0;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end else if (apb_wr && hit_seg) begin
      seg_q[seg_wi] <= pwdata;
    end
  end

  // ==========================================================================
  // lookup datapath, valid while in ST_LOOKUP
  wire             trans     = fetch_q ? ctrl_q[CTRL_IR] : ctrl_q[CTRL_DR];
  wire [31:0]      seg       = seg_q[ea_q[31:28]];
  wire             dstore    = seg[SEG_T];
  wire [VA_W-1:0]  vaddr     = {seg[VSID_W-1:0], ea_q[27:0]};
  wire             tsel      = fetch_q ? 1'(TLB_I) : 1'(TLB_D);
  wire [TLB_IW-1:0] tidx     = ea_q[PG_SH +: TLB_IW];
  wire [TAG_W-1:0] ttag      = vaddr[VA_W-1 -: TAG_W];
  wire             tlb_hit   = tlb_v_q[tsel][tidx] && tlb_tag_q[tsel][tidx] == ttag;
  wire [4:0]       tattr     = tlb_attr_q[tsel][tidx];
  wire [1:0]       t_pp      = tattr[4:3];
  wire             t_guard   = tattr[2];
  wire             t_wt      = tattr[1];
  wire             t_ci      = tattr[0];

  // operation classes
  wire is_store  = op_q inside {OP_STORE, OP_FP_STORE, OP_STMW, OP_STRING_STORE,
                                OP_STORE_COND, OP_EXT_OUT, OP_CACHE_ZERO};
  wire is_multi  = op_q inside {OP_LMW, OP_STMW, OP_STRING_LOAD, OP_STRING_STORE};
  wire is_word   = op_q inside {OP_FP_LOAD, OP_FP_STORE, OP_LMW, OP_STMW,
                                OP_LOAD_RESERVE, OP_STORE_COND, OP_EXT_IN, OP_EXT_OUT};
  wire is_ext    = op_q inside {OP_EXT_IN, OP_EXT_OUT};

  // protection: fetch counts as a read, stores need read/write
  wire pg_ok     = is_store && !fetch_q ? t_pp == PP_RW : t_pp != PP_NONE;

  // alignment causes; string and multiple checks apply even untranslated
  wire al_le     = is_multi && ctrl_q[CTRL_LE];
  wire al_mis    = trans && is_word && ea_q[1:0] != 2'h0;
  wire al_dz     = trans && op_q == OP_CACHE_ZERO &&
                   (bat_hit ? (bat_wt || bat_ci) : (!dstore && tlb_hit && (t_wt || t_ci)));
  wire align     = !fetch_q && (al_le || al_mis || al_dz);
  wire ext_off   = !fetch_q && is_ext && !ctrl_q[CTRL_EXT];
  wire early     = align || !trans || ext_off;
  wire need_walk = !early && !bat_hit && !dstore && !(fetch_q && seg[SEG_N]) && !tlb_hit;

  // ==========================================================================
  // classification; first matching cause wins
  fault_t      f_d;
  logic [31:0] sms_d;
  logic [31:0] dfc_d;
  logic [31:0] pa_d;

  always_comb begin
    f_d   = FAULT_NONE;
    sms_d = 32'h0;
    dfc_d = 32'h0;
    pa_d  = ea_q;
    if (align) begin
      f_d = FAULT_ALIGN;
    end else if (!trans) begin
      pa_d = ea_q;
    end else if (ext_off) begin
      f_d   = FAULT_DATA;
      dfc_d = cause_bit(BIT_EXT);
    end else if (bat_hit) begin
      pa_d = bat_pa;
      if (fetch_q && bat_guard) begin
        f_d   = FAULT_INSTR;
        sms_d = cause_bit(BIT_NOEX);
      end else if (!bat_prot_ok) begin
        f_d   = fetch_q ? FAULT_INSTR : FAULT_DATA;
        sms_d = fetch_q ? cause_bit(BIT_PROT) : 32'h0;
        dfc_d = fetch_q ? 32'h0 : cause_bit(BIT_PROT);
      end
    end else if (dstore) begin
      f_d   = fetch_q ? FAULT_INSTR : FAULT_DATA;
      sms_d = fetch_q ? cause_bit(BIT_NOEX) : 32'h0;
      dfc_d = fetch_q ? 32'h0 : cause_bit(BIT_DST);
    end else if (fetch_q && seg[SEG_N]) begin
      f_d   = FAULT_INSTR;
      sms_d = cause_bit(BIT_NOEX);
    end else begin
      pa_d = {tlb_rpn_q[tsel][tidx], ea_q[PG_SH-1:0]};
      if (fetch_q && t_guard) begin
        f_d   = FAULT_INSTR;
        sms_d = cause_bit(BIT_NOEX);
      end else if (!pg_ok) begin
        f_d   = fetch_q ? FAULT_INSTR : FAULT_DATA;
        sms_d = fetch_q ? cause_bit(BIT_PROT) : 32'h0;
        dfc_d = fetch_q ? 32'h0 : cause_bit(BIT_PROT);
      end
    end
  end

  // ==========================================================================
  // sequencing: idle, one lookup cycle, optional table search then retry
  wire take     = state_q == ST_IDLE && req_valid && req_ready_q;
  wire look_end = state_q == ST_LOOKUP && !need_walk;
  wire walk_hit = state_q == ST_WALK && walk_done && walk_found;
  wire walk_mis = state_q == ST_WALK && walk_done && !walk_found;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   if (take) state_q <= ST_LOOKUP;
        ST_LOOKUP: state_q <= need_walk ? ST_WALK : ST_IDLE;
        ST_WALK:   if (walk_done) state_q <= walk_found ? ST_LOOKUP : ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture; the core need not hold its request after acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ready_q <= 1'b0;
      fetch_q     <= 1'b0;
      op_q        <= OP_LOAD;
      ea_q        <= '0;
      iaddr_q     <= '0;
    end else begin
      req_ready_q <= state_q == ST_IDLE ? !take : (look_end || walk_mis);
      if (take) begin
        fetch_q <= req_fetch;
        op_q    <= req_op;
        ea_q    <= req_ea;
        iaddr_q <= req_iaddr;
      end
    end
  end

  // table search request held until the searcher reports done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      walk_req_q   <= 1'b0;
      walk_vaddr_q <= '0;
    end else if (state_q == ST_LOOKUP && need_walk) begin
      walk_req_q   <= 1'b1;
      walk_vaddr_q <= vaddr;
    end else if (walk_done) begin
      walk_req_q   <= 1'b0;
    end
  end

  // ==========================================================================
  // lookaside buffers: valid bits reset per entry, payload needs no reset
  for (genvar e = 0; e < NE; e++) begin : g_tlb
    for (genvar s = 0; s < 2; s++) begin : g_side
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tlb_v_q[s][e] <= 1'b0;
        end else if (walk_hit && tsel == 1'(s) && tidx == TLB_IW'(e)) begin
          tlb_v_q[s][e] <= 1'b1;
        end else if (tlb_flush) begin
          tlb_v_q[s][e] <= 1'b0;
        end
      end
    end
  end

  // fill payload alongside the valid bit
  always_ff @(posedge pclk) begin
    if (walk_hit) begin
      tlb_tag_q[tsel][tidx]  <= ttag;
      tlb_rpn_q[tsel][tidx]  <= walk_rpn;
      tlb_attr_q[tsel][tidx] <= {walk_pp, walk_guard, walk_wt, walk_ci};
    end
  end

  // ==========================================================================
  // result flops: fault type and cause bits leave together in one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid_q <= 1'b0;
      resp_real_q  <= 1'b0;
      resp_pa_q    <= '0;
      resp_fault_q <= FAULT_NONE;
      resp_sms_q   <= 32'h0;
      resp_dfc_q   <= 32'h0;
      last_fault_q <= FAULT_NONE;
      resp_iaddr_q <= '0;
    end else begin
      resp_valid_q <= look_end || walk_mis;
      if (look_end) begin
        resp_real_q  <= !trans;
        resp_pa_q    <= pa_d;
        resp_fault_q <= f_d;
        resp_sms_q   <= sms_d;
        resp_dfc_q   <= dfc_d;
      end else if (walk_mis) begin
        resp_real_q  <= 1'b0;
        resp_fault_q <= fetch_q ? FAULT_INSTR : FAULT_DATA;
        resp_sms_q   <= fetch_q ? cause_bit(BIT_PAGE) : 32'h0;
        resp_dfc_q   <= fetch_q ? 32'h0 : cause_bit(BIT_PAGE);
      end
      if ((look_end && f_d != FAULT_NONE) || walk_mis) begin
        resp_iaddr_q <= iaddr_q;
        last_fault_q <= look_end ? f_d : (fetch_q ? FAULT_INSTR : FAULT_DATA);
      end
    end
  end

  // output wiring, all straight from flops
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign req_ready        = req_ready_q;
  assign walk_req         = walk_req_q;
  assign walk_vaddr       = walk_vaddr_q;
  assign resp_valid       = resp_valid_q;
  assign resp_real        = resp_real_q;
  assign resp_pa          = resp_pa_q;
  assign resp_fault       = resp_fault_q;
  assign resp_sms         = resp_sms_q;
  assign resp_dfc         = resp_dfc_q;
  assign resp_fault_iaddr = resp_iaddr_q;

  // ==========================================================================
  // checks
  sequence walk_fill_s;
    state_q == ST_WALK && walk_done && walk_found;
  endsequence

  sequence walk_miss_s;
    state_q == ST_WALK && walk_done && !walk_found;
  endsequence

  real_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_LOOKUP && !trans && !align |=> resp_valid && resp_real && resp_pa == ea_q)
    else $error("real mode address differs from effective address");

  bat_prot_a: assert property (@(posedge pclk) disable iff (!presetn)
    look_end && !early && bat_hit && !bat_prot_ok && !(fetch_q && bat_guard)
    |=> resp_fault != FAULT_NONE && (resp_sms | resp_dfc) == cause_bit(BIT_PROT))
    else $error("block protection violation not reported with bit 4");

  walk_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == ST_LOOKUP && need_walk |=> walk_req && walk_vaddr == $past(vaddr))
    else $error("table search not started with the virtual address");

  retry_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
    walk_fill_s |=> state_q == ST_LOOKUP && tlb_hit ##1 resp_valid)
    else $error("retry after fill did not hit");

  page_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    walk_miss_s |=> resp_valid && (resp_sms | resp_dfc) == cause_bit(BIT_PAGE))
    else $error("page fault without cause bit 1");

  dstore_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    look_end && !early && !bat_hit && dstore && !fetch_q
    |=> resp_fault == FAULT_DATA && resp_dfc == cause_bit(BIT_DST))
    else $error("direct-store data access not faulted with bit 5");

  real_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    resp_valid && resp_real |-> resp_fault inside {FAULT_NONE, FAULT_ALIGN})
    else $error("non-alignment fault raised without translation");

  fault_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    resp_valid && resp_fault != FAULT_NONE |-> resp_fault_iaddr == iaddr_q)
    else $error("failing instruction address not saved");

  fault_code_a: assert property (@(posedge pclk) disable iff (!presetn)
    resp_valid |-> (resp_fault == FAULT_INSTR ? resp_dfc == 32'h0 && resp_sms != 32'h0
                  : resp_sms == 32'h0))
    else $error("cause bits do not match the fault type");

endmodule : xlate_fault_unit
`default_nettype wire

// [verilog/xlate_pkg.sv]
// constants, types and helpers shared by the address translation fault logic
// ============================================================================
package xlate_pkg;

  // ==========================================================================
  // register map, byte addresses on the APB
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] FPC_OFF  = 12'h008;
  localparam logic [11:0] SEG_OFF  = 12'h040;

  // control register bit positions
  localparam int CTRL_IR    = 0;
  localparam int CTRL_DR    = 1;
  localparam int CTRL_LE    = 2;
  localparam int CTRL_EXT   = 3;
  localparam int CTRL_FLUSH = 4;
  localparam int CTRL_W     = 4;

  // segment register fields
  localparam int SEG_T  = 31;
  localparam int SEG_N  = 28;
  localparam int VSID_W = 24;

  // ==========================================================================
  // address geometry
  localparam int EA_W  = 32;
  localparam int VA_W  = 52;
  localparam int PG_SH = 12;
  localparam int RPN_W = 20;
  localparam int TLB_I = 0;
  localparam int TLB_D = 1;

  // page protection codes: none, read only, read/write
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_RW   = 2'h2;

  // cause bit numbers, bit 0 is the most significant
  localparam int BIT_PAGE = 1;
  localparam int BIT_NOEX = 3;
  localparam int BIT_PROT = 4;
  localparam int BIT_DST  = 5;
  localparam int BIT_EXT  = 11;

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    OP_LOAD, OP_STORE, OP_FP_LOAD, OP_FP_STORE, OP_LMW, OP_STMW,
    OP_STRING_LOAD, OP_STRING_STORE, OP_LOAD_RESERVE, OP_STORE_COND,
    OP_EXT_IN, OP_EXT_OUT, OP_CACHE_ZERO
  } op_t;

  typedef enum logic [1:0] {
    FAULT_NONE, FAULT_INSTR, FAULT_DATA, FAULT_ALIGN
  } fault_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_LOOKUP = 3'b010,
    ST_WALK   = 3'b100
  } state_t;

  // one-hot cause vector with bit 0 at the most significant end
  function automatic logic [31:0] cause_bit(input int n);
    return 32'h8000_0000 >> n;
  endfunction : cause_bit

endpackage : xlate_pkg
